// file: src/imc_map.svh
// Register offsets, field positions, reset values and timing counts of the mode control block.
`ifndef IMC_MAP_SVH
`define IMC_MAP_SVH

`define IMC_OFF_OWN_ADDR 8'h00
`define IMC_OFF_WORD_COUNT 8'h04
`define IMC_OFF_TARGET_ADDR 8'h08
`define IMC_OFF_TX_DATA 8'h0C
`define IMC_OFF_RX_DATA 8'h10
`define IMC_OFF_MODE 8'h14
`define IMC_OFF_STATUS 8'h18

`define IMC_MC_START_BIT 13
`define IMC_MC_RSVD_BIT 12
`define IMC_MC_STOP_BIT 11
`define IMC_MC_MASTER_BIT 10
`define IMC_MC_TRX_BIT 9
`define IMC_MC_XA_BIT 8
`define IMC_MC_REPEAT_BIT 7

`define IMC_ST_BUSY_BIT 0
`define IMC_ST_SLV_ACTIVE_BIT 1
`define IMC_ST_NACK_BIT 2
`define IMC_ST_SLV_TX_BIT 3
`define IMC_ST_COUNT_LSB 16

`define IMC_RST_MODE 6'h00
`define IMC_RST_ADDR 10'h000
`define IMC_RST_COUNT 16'h0000
`define IMC_RST_DATA 8'h00

`define IMC_TEN_BIT_HDR 5'h1E

`define IMC_CLK_PERIOD_NS 5
`define IMC_SCL_PERIOD_NS 10000
`define IMC_QTR_CYCLES ((`IMC_SCL_PERIOD_NS / 4) / `IMC_CLK_PERIOD_NS)

`endif

// file: src/imc_pkg.sv
// Types shared by the mode control block.
package imc_pkg;

    typedef struct packed {
        logic start_request;
        logic stop_request;
        logic master_select;
        logic transmit_select;
        logic expanded_addressing;
        logic repeat_mode;
    } imc_mode_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_BIT = 3'b010,
        M_HOLD = 3'b011,
        M_STOP = 3'b100
    } imc_mstate_t;

    typedef enum logic [1:0] {
        PH_ADDR1 = 2'b00,
        PH_ADDR2 = 2'b01,
        PH_DATA = 2'b10
    } imc_phase_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ADDR2 = 3'b010,
        S_RX = 3'b011,
        S_TX = 3'b100
    } imc_sstate_t;

endpackage : imc_pkg

// file: src/imc_top.sv
// Mode control bits with master and slave serial engines behind an APB slave.
// Overview of operation
// - Start request at bit 13, used by master and slave.
// - Master clears start request after START.
// - Writing start request as master sends START.
// - Slave with start request 0 ignores bus.
// - Slave with start request 1 serves masters.
// - Bit 12 reads zero, writes ignored.
// - Stop request issues STOP at count zero, or after the current word in repeat mode.
// - Stop request clears after STOP generated.
// - Master select drops to 0 on STOP.
// - Master drives clock; slave takes it.
// - Transmit select chooses send or receive.
// - Seven-bit addressing uses bits 6-0.
// - Ten-bit addressing uses bits 9-0.
// - Non-repeat moves exactly word count words.
// - Repeat mode runs until stop request.
// - Slave ignores repeat mode bit.
`include "imc_map.svh"
module imc_top
    import imc_pkg::*;
#(
    parameter int QTR_CYCLES = `IMC_QTR_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    if (QTR_CYCLES < 4 || QTR_CYCLES > 65535) begin : g_bad_qtr
        $error("QTR_CYCLES must lie between 4 and 65535");
    end

    // Registers reached over APB.
    imc_mode_t mode_ff;
    logic [9:0] own_addr_ff;
    logic [9:0] target_addr_ff;
    logic [15:0] word_count_ff;
    logic [7:0] tx_data_ff;
    logic [7:0] rx_data_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // Pin synchronisers; the first stage feeds only the second.
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic scl_oe_ff, sda_oe_ff, pin_low_ff;

    // Master engine.
    imc_mstate_t m_state_ff, nxt_m_state;
    imc_phase_t m_phase_ff, nxt_m_phase;
    logic [1:0] m_q_ff, nxt_m_q;
    logic [3:0] m_bit_ff, nxt_m_bit;
    logic [7:0] m_sh_ff, nxt_m_sh;
    logic [15:0] m_cnt_ff, nxt_m_cnt;
    logic [15:0] tick_ff;
    logic m_scl_oe_ff, nxt_m_scl_oe;
    logic m_sda_oe_ff, nxt_m_sda_oe;
    logic nack_ff, nxt_nack;
    logic clr_start, clr_stop, m_rx_load;

    // Slave engine.
    imc_sstate_t s_state_ff, nxt_s_state;
    logic [3:0] s_cnt_ff, nxt_s_cnt;
    logic [7:0] s_sh_ff, nxt_s_sh;
    logic s_oe_ff, nxt_s_oe;
    logic s_rx_load;

    // APB decode: the access phase lasts two cycles so that every answer comes from a flop.
    wire apb_access = psel && penable;
    wire apb_done = apb_access && pready_ff;
    wire wr_en = apb_done && pwrite;
    wire wr_own = wr_en && (paddr == `IMC_OFF_OWN_ADDR);
    wire wr_count = wr_en && (paddr == `IMC_OFF_WORD_COUNT);
    wire wr_target = wr_en && (paddr == `IMC_OFF_TARGET_ADDR);
    wire wr_tx = wr_en && (paddr == `IMC_OFF_TX_DATA);
    wire wr_mode = wr_en && (paddr == `IMC_OFF_MODE);
    wire addr_hit = (paddr == `IMC_OFF_OWN_ADDR) || (paddr == `IMC_OFF_WORD_COUNT) ||
                    (paddr == `IMC_OFF_TARGET_ADDR) || (paddr == `IMC_OFF_TX_DATA) ||
                    (paddr == `IMC_OFF_RX_DATA) || (paddr == `IMC_OFF_MODE) ||
                    (paddr == `IMC_OFF_STATUS);

    wire [31:0] rd_mode = (32'(mode_ff.start_request) << `IMC_MC_START_BIT) |
                          (32'(mode_ff.stop_request) << `IMC_MC_STOP_BIT) |
                          (32'(mode_ff.master_select) << `IMC_MC_MASTER_BIT) |
                          (32'(mode_ff.transmit_select) << `IMC_MC_TRX_BIT) |
                          (32'(mode_ff.expanded_addressing) << `IMC_MC_XA_BIT) |
                          (32'(mode_ff.repeat_mode) << `IMC_MC_REPEAT_BIT);
    wire [31:0] rd_status = (32'(m_cnt_ff) << `IMC_ST_COUNT_LSB) |
                            (32'(s_state_ff == S_TX) << `IMC_ST_SLV_TX_BIT) |
                            (32'(nack_ff) << `IMC_ST_NACK_BIT) |
                            (32'(s_state_ff != S_IDLE) << `IMC_ST_SLV_ACTIVE_BIT) |
                            (32'(m_state_ff != M_IDLE) << `IMC_ST_BUSY_BIT);
    wire [31:0] rd_data = (paddr == `IMC_OFF_OWN_ADDR) ? 32'(own_addr_ff) :
                          (paddr == `IMC_OFF_WORD_COUNT) ? 32'(word_count_ff) :
                          (paddr == `IMC_OFF_TARGET_ADDR) ? 32'(target_addr_ff) :
                          (paddr == `IMC_OFF_TX_DATA) ? 32'(tx_data_ff) :
                          (paddr == `IMC_OFF_RX_DATA) ? 32'(rx_data_ff) :
                          (paddr == `IMC_OFF_MODE) ? rd_mode :
                          (paddr == `IMC_OFF_STATUS) ? rd_status : 32'h00000000;

    // Mode register as written, before the engines clear their bits.
    wire [31:0] wd = pwdata;
    wire imc_mode_t wr_mode_val = '{start_request: wd[`IMC_MC_START_BIT], stop_request: wd[`IMC_MC_STOP_BIT],
                                    master_select: wd[`IMC_MC_MASTER_BIT], transmit_select: wd[`IMC_MC_TRX_BIT],
                                    expanded_addressing: wd[`IMC_MC_XA_BIT], repeat_mode: wd[`IMC_MC_REPEAT_BIT]};
    wire imc_mode_t mode_wr = wr_mode ? wr_mode_val : mode_ff;

    // Bus events seen through the synchronisers.
    wire scl_rise = scl_s2_ff && !scl_d_ff;
    wire scl_fall = !scl_s2_ff && scl_d_ff;
    wire start_det = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
    wire stop_det = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;

    wire tick = (tick_ff == 16'(QTR_CYCLES - 1));
    wire xa = mode_ff.expanded_addressing;
    wire [7:0] addr_byte0 = xa ? {`IMC_TEN_BIT_HDR, target_addr_ff[9:8], 1'b0} :
                                 {target_addr_ff[6:0], !mode_ff.transmit_select};
    wire m_tx_now = (m_phase_ff != PH_DATA) || mode_ff.transmit_select;
    wire m_count_step = (m_phase_ff == PH_DATA) && !mode_ff.repeat_mode && (m_cnt_ff != 16'h0000);
    wire [15:0] m_cnt_after = m_count_step ? m_cnt_ff - 16'h0001 : m_cnt_ff;
    wire m_words_done = !mode_ff.repeat_mode && (m_cnt_after == 16'h0000);
    wire m_last_rx = !mode_ff.repeat_mode && (m_cnt_ff == 16'h0001);
    wire slave_en = !mode_ff.master_select && mode_ff.start_request;

    always_comb begin
        nxt_m_state = m_state_ff;
        nxt_m_phase = m_phase_ff;
        nxt_m_q = m_q_ff;
        nxt_m_bit = m_bit_ff;
        nxt_m_sh = m_sh_ff;
        nxt_m_cnt = m_cnt_ff;
        nxt_m_scl_oe = m_scl_oe_ff;
        nxt_m_sda_oe = m_sda_oe_ff;
        nxt_nack = nack_ff;
        clr_start = 1'b0;
        clr_stop = 1'b0;
        m_rx_load = 1'b0;
        case (m_state_ff)
            M_IDLE: begin
                nxt_m_scl_oe = 1'b0;
                nxt_m_sda_oe = 1'b0;
                nxt_m_q = 2'd0;
                if (mode_ff.master_select && mode_ff.start_request) begin
                    nxt_m_state = M_START;
                end
            end
            M_START: if (tick) begin
                nxt_m_q = m_q_ff + 2'd1;
                case (m_q_ff)
                    2'd0: nxt_m_sda_oe = 1'b0;
                    2'd1: nxt_m_scl_oe = 1'b0;
                    2'd2: nxt_m_sda_oe = 1'b1;
                    default: begin
                        nxt_m_scl_oe = 1'b1;
                        nxt_m_state = M_BIT;
                        nxt_m_phase = PH_ADDR1;
                        nxt_m_bit = 4'd0;
                        nxt_m_sh = addr_byte0;
                        nxt_m_cnt = word_count_ff;
                        clr_start = 1'b1;
                    end
                endcase
            end
            M_BIT: if (tick) begin
                nxt_m_q = m_q_ff + 2'd1;
                case (m_q_ff)
                    2'd0: begin
                        if (m_bit_ff < 4'd8) begin
                            nxt_m_sda_oe = m_tx_now && !m_sh_ff[7];
                        end else begin
                            nxt_m_sda_oe = !m_tx_now && !m_last_rx;
                        end
                    end
                    2'd1: nxt_m_scl_oe = 1'b1;
                    2'd2: nxt_m_scl_oe = 1'b0;
                    default: begin
                        nxt_m_scl_oe = 1'b1;
                        if (m_bit_ff < 4'd8) begin
                            nxt_m_sh = {m_sh_ff[6:0], sda_s2_ff};
                            nxt_m_bit = m_bit_ff + 4'd1;
                        end else begin
                            nxt_m_bit = 4'd0;
                            // An acknowledge stays driven until the next quarter, so SDA never moves with SCL.
                            nxt_m_sh = tx_data_ff;
                            if (m_tx_now) begin
                                nxt_nack = sda_s2_ff;
                            end
                            case (m_phase_ff)
                                PH_ADDR1: begin
                                    if (xa) begin
                                        nxt_m_phase = PH_ADDR2;
                                        nxt_m_sh = target_addr_ff[7:0];
                                    end else begin
                                        nxt_m_phase = PH_DATA;
                                    end
                                end
                                PH_ADDR2: nxt_m_phase = PH_DATA;
                                default: begin
                                    m_rx_load = !m_tx_now;
                                    nxt_m_cnt = m_cnt_after;
                                end
                            endcase
                            if (nxt_m_phase == PH_DATA) begin
                                nxt_m_q = 2'd0;
                                if (mode_ff.start_request) begin
                                    nxt_m_state = M_START;
                                end else if (mode_ff.stop_request && (mode_ff.repeat_mode || m_words_done)) begin
                                    nxt_m_state = M_STOP;
                                end else if (m_words_done) begin
                                    nxt_m_state = M_HOLD;
                                end
                            end
                        end
                    end
                endcase
            end
            M_HOLD: begin
                nxt_m_q = 2'd0;
                if (mode_ff.start_request) begin
                    nxt_m_state = M_START;
                end else if (mode_ff.stop_request) begin
                    nxt_m_state = M_STOP;
                end
            end
            M_STOP: if (tick) begin
                nxt_m_q = m_q_ff + 2'd1;
                case (m_q_ff)
                    2'd0: nxt_m_sda_oe = 1'b1;
                    2'd1: nxt_m_scl_oe = 1'b0;
                    2'd2: nxt_m_sda_oe = 1'b0;
                    default: begin
                        nxt_m_state = M_IDLE;
                        clr_stop = 1'b1;
                    end
                endcase
            end
            default: nxt_m_state = M_IDLE;
        endcase
    end

    // Slave engine; it never stretches the clock, so a slow host can miss a received byte.
    always_comb begin
        nxt_s_state = s_state_ff;
        nxt_s_cnt = s_cnt_ff;
        nxt_s_sh = s_sh_ff;
        nxt_s_oe = s_oe_ff;
        s_rx_load = 1'b0;
        if (!slave_en) begin
            nxt_s_state = S_IDLE;
            nxt_s_oe = 1'b0;
        end else if (start_det) begin
            nxt_s_state = S_ADDR;
            nxt_s_cnt = 4'd0;
            nxt_s_oe = 1'b0;
        end else if (stop_det) begin
            nxt_s_state = S_IDLE;
            nxt_s_oe = 1'b0;
        end else if (s_state_ff != S_IDLE && scl_rise) begin
            if (s_cnt_ff < 4'd8) begin
                nxt_s_sh = {s_sh_ff[6:0], sda_s2_ff};
                nxt_s_cnt = s_cnt_ff + 4'd1;
            end else begin
                nxt_s_cnt = 4'd0;
                if (s_state_ff == S_TX && sda_s2_ff) begin
                    nxt_s_state = S_IDLE;
                end
            end
        end else if (s_state_ff != S_IDLE && scl_fall) begin
            nxt_s_oe = 1'b0;
            if (s_cnt_ff == 4'd8) begin
                case (s_state_ff)
                    S_ADDR: begin
                        if (!xa && s_sh_ff[7:1] == own_addr_ff[6:0]) begin
                            nxt_s_oe = 1'b1;
                            nxt_s_state = s_sh_ff[0] ? S_TX : S_RX;
                        end else if (xa && s_sh_ff[7:1] == {`IMC_TEN_BIT_HDR, own_addr_ff[9:8]}) begin
                            nxt_s_oe = 1'b1;
                            nxt_s_state = S_ADDR2;
                        end else begin
                            nxt_s_state = S_IDLE;
                        end
                    end
                    S_ADDR2: begin
                        nxt_s_oe = (s_sh_ff == own_addr_ff[7:0]);
                        nxt_s_state = (s_sh_ff == own_addr_ff[7:0]) ? S_RX : S_IDLE;
                    end
                    S_RX: begin
                        nxt_s_oe = 1'b1;
                        s_rx_load = 1'b1;
                    end
                    default: nxt_s_oe = 1'b0;
                endcase
            end else if (s_state_ff == S_TX) begin
                nxt_s_oe = !tx_data_ff[3'd7 - s_cnt_ff[2:0]];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_ff <= `IMC_RST_MODE;
        end else begin
            mode_ff <= mode_wr;
            if (clr_start) begin
                mode_ff.start_request <= 1'b0;
            end
            if (clr_stop) begin
                mode_ff.stop_request <= 1'b0;
                mode_ff.master_select <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            own_addr_ff <= `IMC_RST_ADDR;
            target_addr_ff <= `IMC_RST_ADDR;
            word_count_ff <= `IMC_RST_COUNT;
            tx_data_ff <= `IMC_RST_DATA;
            rx_data_ff <= `IMC_RST_DATA;
        end else begin
            own_addr_ff <= wr_own ? pwdata[9:0] : own_addr_ff;
            target_addr_ff <= wr_target ? pwdata[9:0] : target_addr_ff;
            word_count_ff <= wr_count ? pwdata[15:0] : word_count_ff;
            tx_data_ff <= wr_tx ? pwdata[7:0] : tx_data_ff;
            rx_data_ff <= m_rx_load ? m_sh_ff : (s_rx_load ? s_sh_ff : rx_data_ff);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= apb_access && !pready_ff;
            pslverr_ff <= apb_access && !pready_ff && !addr_hit;
            prdata_ff <= (apb_access && !pready_ff && !pwrite) ? rd_data : 32'h00000000;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
            {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            pin_low_ff <= 1'b0;
        end else begin
            {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
            {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
            scl_oe_ff <= m_scl_oe_ff;
            sda_oe_ff <= m_sda_oe_ff || s_oe_ff;
            pin_low_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            m_state_ff <= M_IDLE;
            m_phase_ff <= PH_ADDR1;
            m_q_ff <= 2'd0;
            m_bit_ff <= 4'd0;
            m_sh_ff <= 8'h00;
            m_cnt_ff <= 16'h0000;
            tick_ff <= 16'h0000;
            m_scl_oe_ff <= 1'b0;
            m_sda_oe_ff <= 1'b0;
            nack_ff <= 1'b0;
            s_state_ff <= S_IDLE;
            s_cnt_ff <= 4'd0;
            s_sh_ff <= 8'h00;
            s_oe_ff <= 1'b0;
        end else begin
            m_state_ff <= nxt_m_state;
            m_phase_ff <= nxt_m_phase;
            m_q_ff <= nxt_m_q;
            m_bit_ff <= nxt_m_bit;
            m_sh_ff <= nxt_m_sh;
            m_cnt_ff <= nxt_m_cnt;
            tick_ff <= (m_state_ff == M_IDLE || tick) ? 16'h0000 : tick_ff + 16'h0001;
            m_scl_oe_ff <= nxt_m_scl_oe;
            m_sda_oe_ff <= nxt_m_sda_oe;
            nack_ff <= nxt_nack;
            s_state_ff <= nxt_s_state;
            s_cnt_ff <= nxt_s_cnt;
            s_sh_ff <= nxt_s_sh;
            s_oe_ff <= nxt_s_oe;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign scl_out = pin_low_ff;
    assign sda_out = pin_low_ff;
    assign scl_oe = scl_oe_ff;
    assign sda_oe = sda_oe_ff;

endmodule : imc_top

// file: tb/imc_chk.sv
// Port-level checker for the mode control block.
module imc_chk
    import imc_pkg::*;
#(
    parameter int QTR_CYCLES = 500
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_out,
    input wire logic sda_out,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QLIM = 600;
    logic en_ff;
    logic ms_ff;
    wire mode_wr = psel && penable && pready && pwrite && paddr == 8'h14;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_start;
        ms_ff && !scl_oe && $rose(sda_oe);
    endsequence
    sequence s_stop;
        ms_ff && !scl_oe && $fell(sda_oe);
    endsequence
    // Master ownership is cleared on a STOP so that later clock driving is flagged.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_ff <= 1'b0;
            ms_ff <= 1'b0;
        end else begin
            en_ff <= en_ff || (mode_wr && (pwdata[13] || pwdata[10]));
            ms_ff <= (mode_wr && pwdata[10]) || (ms_ff && !(!scl_oe && $fell(sda_oe)));
        end
    end
    property p_walk;
        $rose(psel && penable) |-> !pready ##1 pready;
    endproperty
    a_walk: assert property (p_walk) else $error("ready not in second access cycle");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err;
        pslverr |-> pready && (paddr > 8'h18 || paddr[1:0] != 2'b00);
    endproperty
    a_err: assert property (p_err) else $error("bad error response");
    property p_rsvd;
        pready && !pwrite && paddr == 8'h14 |-> prdata[31:14] == 18'h0 && !prdata[12] && prdata[6:0] == 7'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode bits not zero");
    property p_quiet;
        !en_ff |-> !sda_oe && !scl_oe && !sda_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus driven while idle slave");
    property p_scl;
        !ms_ff |-> !scl_oe && !scl_out;
    endproperty
    a_scl: assert property (p_scl) else $error("clock driven while not master");
    property p_start;
        s_start |-> ##[1:QLIM] scl_oe;
    endproperty
    a_start: assert property (p_start) else $error("start not followed by clock low");
    property p_stop;
        s_stop |=> !scl_oe [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("clock driven after stop");
endmodule : imc_chk

// file: tb/imc_peer.sv
// Behavioural serial target: acks, logs written bytes and serves reads.
module imc_peer (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] rd_byte,
    output logic sda_oe,
    output logic [31:0] hist,
    output int nbytes
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh;
    int bitn = 99;
    bit rd;
    bit first;
    initial begin
        sda_oe = 1'b0;
        hist = 32'h0;
        nbytes = 0;
    end
    // The clock fall that closes a START carries no bit, so the count starts one below zero.
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bitn = -1;
            first = 1'b1;
            rd = 1'b0;
        end
    end
    // A STOP parks the bit count so that stray clocks cannot make the model drive.
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            sda_oe = 1'b0;
            bitn = 99;
        end
    end
    always @(posedge scl) sh = {sh[6:0], sda};
    always @(negedge scl) begin
        if (bitn == 7) begin
            if (first) rd = sh[0];
            sda_oe = first || !rd;
            if (first || !rd) hist = {hist[23:0], sh};
            if (first || !rd) nbytes++;
        end else if (bitn == 8) begin
            if (!first && sh[0]) rd = 1'b0;
            first = 1'b0;
            sda_oe = rd && !rd_byte[7];
        end else if (rd && !first && bitn < 7) begin
            sda_oe = !rd_byte[6 - bitn];
        end
        bitn = (bitn == 8) ? 0 : bitn + 1;
    end
endmodule : imc_peer

// file: tb/tb_imc_top.sv
// Self-checking bench for the mode control block with a serial target model.
module tb_imc_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QTR = 4;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, rd_byte = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, hist, rv, x, seed = 32'hCA8072B1;
    logic pready, pslverr, scl_oe, sda_oe, p_oe, ev;
    int nbytes, fail_count = 0, checks_done = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || p_oe);
    imc_top #(.QTR_CYCLES(QTR)) dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe));
    imc_peer peer_u (.scl(scl), .sda(sda), .rd_byte(rd_byte), .sda_oe(p_oe), .hist(hist), .nbytes(nbytes));
    initial begin
        forever #2.5 clk = !clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] mode(input logic st, sp, ms, tr, xa, rm);
        return {18'h0, st, 1'b0, sp, ms, tr, xa, rm, 7'h0};
    endfunction : mode
    function automatic logic [31:0] exp_hist(input logic [31:0] h, input logic xa, tr, input logic [9:0] t,
            input logic [7:0] d, input int c);
        if (xa) h = {h[23:0], 5'h1E, t[9:8], 1'b0};
        h = xa ? {h[23:0], t[7:0]} : {h[23:0], t[6:0], !tr};
        if (tr) repeat (c) h = {h[23:0], d};
        return h;
    endfunction : exp_hist
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic hang();
        fail_count++;
        $display("FAIL %0t wait ran out", $time);
        end_of_test();
    endtask : hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready is read at the rising edge, before the slave's flops move on that edge.
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) hang();
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Polls the master bit; a bounded poll keeps a stuck transfer from hanging the run.
    task automatic xfer(input logic xa, rm, tr, input logic [15:0] cnt);
        logic [31:0] h0;
        int b0;
        int k;
        x = xs();
        h0 = hist;
        b0 = nbytes;
        rd_byte <= x[25:18];
        apb(1'b1, 8'h08, {22'h0, xa ? x[9:0] : {3'h0, x[6:0]}});
        apb(1'b1, 8'h0C, {24'h0, x[17:10]});
        apb(1'b1, 8'h04, {16'h0, cnt});
        apb(1'b1, 8'h14, mode(1'b1, !rm, 1'b1, tr, xa, rm));
        if (rm) repeat (QTR * 36 * 6) @(posedge clk);
        if (rm) apb(1'b1, 8'h14, mode(1'b0, 1'b1, 1'b1, tr, xa, rm));
        for (k = 0; k < 500; k++) begin
            apb(1'b0, 8'h14, 32'h0);
            if (rv[10] === 1'b0) break;
        end
        if (k == 500) hang();
        chk(rv, mode(1'b0, 1'b0, 1'b0, tr, xa, rm));
        if (rm) chk({31'h0, nbytes - b0 > 4}, 32'h1);
        if (!rm) chk(nbytes - b0, (xa ? 2 : 1) + (tr ? cnt : 0));
        if (!rm) chk(hist, exp_hist(h0, xa, tr, xa ? x[9:0] : {3'h0, x[6:0]}, x[17:10], cnt));
        apb(1'b0, 8'h10, 32'h0);
        if (!tr) chk(rv, {24'h0, x[25:18]});
    endtask : xfer
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, 8'h14, 32'h0);
        chk(rv, 32'h0);
        apb(1'b1, 8'h14, 32'hFFFF_D380);
        apb(1'b0, 8'h14, 32'h0);
        chk(rv, 32'h0000_0380);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        apb(1'b1, 8'h14, 32'h0);
        xfer(1'b0, 1'b0, 1'b1, 16'h0001);
        xfer(1'b1, 1'b0, 1'b1, 16'h0001);
        xfer(1'b0, 1'b0, 1'b1, 16'h0002);
        xfer(1'b0, 1'b0, 1'b0, 16'h0001);
        xfer(1'b0, 1'b1, 1'b1, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            x = xs();
            xfer(x[0], 1'b0, x[1] | x[0], {14'h0, x[3:2]} + 16'h0001);
        end
        end_of_test();
    end
endmodule : tb_imc_top
bind imc_top imc_chk #(.QTR_CYCLES(QTR_CYCLES)) chk_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_out(scl_out), .sda_out(sda_out), .scl_oe(scl_oe), .sda_oe(sda_oe));
